//--- logic/adcseq_consts.svh
/*
 Offsets-free field layout, reset values and timing counts of the converter sequencer.
 Assumes it is included by bare name from the package only.
*/
`ifndef ADCSEQ_CONSTS_SVH
`define ADCSEQ_CONSTS_SVH

`define ADCSEQ_RES_W 8
`define ADCSEQ_CYC_W 11
`define ADCSEQ_CC1_START_BIT 7
`define ADCSEQ_CC1_FIX1_BIT 5
`define ADCSEQ_CC1_DIS_BIT 4
`define ADCSEQ_CC1_CH_MSB 3
`define ADCSEQ_CC1_CH_LSB 0
`define ADCSEQ_CC2_MODE_BIT 5
`define ADCSEQ_CC2_FIX1_BIT 4
`define ADCSEQ_CC2_TS_MSB 3
`define ADCSEQ_CC2_TS_LSB 1
`define ADCSEQ_ST_EOC_BIT 5
`define ADCSEQ_ST_BUSY_BIT 4
`define ADCSEQ_CH_RST 4'h0
`define ADCSEQ_DIS_RST 1'b1
`define ADCSEQ_MODE_RST 1'b0
`define ADCSEQ_TS_RST 3'h0
`define ADCSEQ_RESULT_RST 8'h00
`define ADCSEQ_SAR_FIRST 8'h80
`define ADCSEQ_TS_39 3'h0
`define ADCSEQ_TS_78 3'h2
`define ADCSEQ_TS_156 3'h3
`define ADCSEQ_TS_312 3'h4
`define ADCSEQ_TS_624 3'h5
`define ADCSEQ_TS_1248 3'h6
`define ADCSEQ_TCONV_39 11'd39
`define ADCSEQ_TCONV_78 11'd78
`define ADCSEQ_TCONV_156 11'd156
`define ADCSEQ_TCONV_312 11'd312
`define ADCSEQ_TCONV_624 11'd624
`define ADCSEQ_TCONV_1248 11'd1248

`endif

//--- logic/adcseq_pkg.sv
/*
 Types of the converter sequencer: state codes and the packed state of each module.
 Assumes adcseq_consts.svh is on the include path.
*/
`include "adcseq_consts.svh"

package adcseq_pkg;
    typedef logic [`ADCSEQ_RES_W-1:0] adcseq_code_t;

    typedef enum logic [1:0] {
        ADCSEQ_IDLE = 2'b01,
        ADCSEQ_CONV = 2'b10
    } adcseq_state_t;

    typedef struct packed {
        adcseq_state_t st;
        logic start;
        logic [3:0] chan;
        logic dis;
        logic mode;
        logic [2:0] tsel;
        logic eoc;
        logic busy;
        logic irq;
        adcseq_code_t result;
        logic [`ADCSEQ_CYC_W-1:0] cyc;
        logic [2:0] step;
        logic [`ADCSEQ_CYC_W-1:0] tconv;
        logic ladder;
        logic comp_m;
        logic comp_s;
    } adcseq_main_t;

    typedef struct packed {
        adcseq_code_t trial;
        adcseq_code_t mask;
    } adcseq_sar_t;
endpackage : adcseq_pkg

//--- logic/adcseq_sar_if.sv
/*
 Link between the sequencer control and its approximation register.
 Assumes both ends share one clock.
*/
`timescale 1ns/1ps
`default_nettype none

interface adcseq_sar_if;
    import adcseq_pkg::*;
    logic start;
    logic abort;
    logic step;
    logic comp;
    adcseq_code_t trial;
    adcseq_code_t decided;
    modport ctrl (output start, output abort, output step, output comp,
                  input trial, input decided);
    modport sar (input start, input abort, input step, input comp,
                 output trial, output decided);
endinterface : adcseq_sar_if

`default_nettype wire

//--- logic/adcseq_sar.sv
/*
 Successive-approximation register: one bit per step, most significant first.
 Assumes the comparator bit it sees is already synchronised and settled.
*/
`timescale 1ns/1ps
`default_nettype none

module adcseq_sar
    import adcseq_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_b_i,
    adcseq_sar_if.sar sar_if
);
    adcseq_sar_t s_q;
    adcseq_sar_t s_d;

    // Trial bit stays when the input is at or above the trial level
    assign sar_if.decided = sar_if.comp ? s_q.trial : (s_q.trial & ~s_q.mask);
    assign sar_if.trial = s_q.trial;

    always_comb begin
        s_d = s_q;
        if (sar_if.abort) begin
            s_d.trial = `ADCSEQ_RESULT_RST;
            s_d.mask = `ADCSEQ_RESULT_RST;
        end else if (sar_if.start) begin
            s_d.trial = `ADCSEQ_SAR_FIRST;
            s_d.mask = `ADCSEQ_SAR_FIRST;
        end else if (sar_if.step) begin
            s_d.trial = sar_if.decided | (s_q.mask >> 1);
            s_d.mask = s_q.mask >> 1;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
endmodule : adcseq_sar

`default_nettype wire

//--- logic/adcseq_top.sv
/*
 Conversion sequencer of an 8-bit successive-approximation converter: control
 registers, conversion timer, status flags, done pulse and stop/slow handling.
 Assumes register accesses arrive as same-clock strobes, low_power_i comes from
 same-clock mode logic, and comp_i comes from the analog comparator pin.
*/
`timescale 1ns/1ps
`default_nettype none

module adcseq_top
    import adcseq_pkg::*;
#(
    parameter int RES_W = `ADCSEQ_RES_W
) (
    input wire logic clk_i,
    input wire logic rst_b_i,
    input wire logic converter_control_1_we_i,
    input wire logic [7:0] converter_control_1_wdata_i,
    input wire logic converter_control_2_we_i,
    input wire logic [7:0] converter_control_2_wdata_i,
    input wire logic conversion_result_re_i,
    input wire logic low_power_i,
    input wire logic comp_i,
    output logic [7:0] converter_control_1_o,
    output logic [7:0] converter_control_2_o,
    output logic [7:0] converter_status_o,
    output logic [7:0] conversion_result_o,
    output logic conv_start_bit_o,
    output logic conv_end_flag_o,
    output logic conv_busy_flag_o,
    output logic conv_done_irq_o,
    output logic [3:0] channel_select_o,
    output logic analog_input_disable_o,
    output logic ladder_connect_mode_o,
    output logic [2:0] conv_time_sel_o,
    output logic analog_reference_connect_o,
    output logic sample_hold_o,
    output logic [7:0] dac_code_o
);
    if (RES_W != `ADCSEQ_RES_W) begin : g_bad_width
        $error("adcseq_top supports an 8-bit result only");
    end

    adcseq_main_t s_q;
    adcseq_main_t s_d;
    logic fire;
    logic fin;
    logic [13:0] fire_lhs;
    logic [13:0] fire_rhs;

    adcseq_sar_if sar_if ();

    adcseq_sar u_sar (
        .clk_i(clk_i),
        .rst_b_i(rst_b_i),
        .sar_if(sar_if)
    );

    function automatic logic [`ADCSEQ_CYC_W-1:0] tconv_of(input logic [2:0] ts);
        logic [`ADCSEQ_CYC_W-1:0] n;
        n = `ADCSEQ_TCONV_1248;
        // Reserved codes fall back to the slowest, safest time
        case (ts)
            `ADCSEQ_TS_39: n = `ADCSEQ_TCONV_39;
            `ADCSEQ_TS_78: n = `ADCSEQ_TCONV_78;
            `ADCSEQ_TS_156: n = `ADCSEQ_TCONV_156;
            `ADCSEQ_TS_312: n = `ADCSEQ_TCONV_312;
            `ADCSEQ_TS_624: n = `ADCSEQ_TCONV_624;
            `ADCSEQ_TS_1248: n = `ADCSEQ_TCONV_1248;
            default: n = `ADCSEQ_TCONV_1248;
        endcase
        return n;
    endfunction : tconv_of

    // Step k ends at the first cycle where 8*(cyc+1) >= (k+1)*N
    assign fire_lhs = {s_q.cyc + 11'd1, 3'b000};
    assign fire_rhs = ({11'd0, s_q.step} + 14'd1) * {3'd0, s_q.tconv};

    always_comb begin
        s_d = s_q;
        fire = 1'b0;
        fin = 1'b0;
        sar_if.start = 1'b0;
        sar_if.abort = 1'b0;
        sar_if.step = 1'b0;
        sar_if.comp = s_q.comp_s;
        // Comparator pin is asynchronous: only comp_s feeds the approximation
        s_d.comp_m = comp_i;
        s_d.comp_s = s_q.comp_m;
        s_d.irq = 1'b0;
        if (converter_control_1_we_i) begin
            s_d.chan = converter_control_1_wdata_i[`ADCSEQ_CC1_CH_MSB:`ADCSEQ_CC1_CH_LSB];
            s_d.dis = converter_control_1_wdata_i[`ADCSEQ_CC1_DIS_BIT];
            if (converter_control_1_wdata_i[`ADCSEQ_CC1_START_BIT] && !s_q.start
                && !s_q.busy) begin
                s_d.start = 1'b1;
            end
        end
        if (converter_control_2_we_i) begin
            s_d.mode = converter_control_2_wdata_i[`ADCSEQ_CC2_MODE_BIT];
            s_d.tsel = converter_control_2_wdata_i[`ADCSEQ_CC2_TS_MSB:`ADCSEQ_CC2_TS_LSB];
        end
        case (s_q.st)
            ADCSEQ_IDLE: begin
                if (s_q.start) begin
                    s_d.st = ADCSEQ_CONV;
                    s_d.start = 1'b0;
                    s_d.busy = 1'b1;
                    s_d.eoc = 1'b0;
                    s_d.cyc = '0;
                    s_d.step = '0;
                    // Time is latched so a rewrite mid-conversion cannot skew steps
                    s_d.tconv = tconv_of(s_q.tsel);
                    sar_if.start = 1'b1;
                end
            end
            ADCSEQ_CONV: begin
                s_d.cyc = s_q.cyc + 11'd1;
                fire = (fire_lhs >= fire_rhs);
                if (fire) begin
                    sar_if.step = 1'b1;
                    s_d.step = s_q.step + 3'd1;
                    if (s_q.step == 3'd7) begin
                        fin = 1'b1;
                        s_d.st = ADCSEQ_IDLE;
                        s_d.busy = 1'b0;
                        s_d.result = sar_if.decided;
                        s_d.irq = 1'b1;
                    end
                end
            end
            default: begin
                s_d.st = ADCSEQ_IDLE;
            end
        endcase
        // A completion in the same cycle as a read wins
        if (fin) begin
            s_d.eoc = 1'b1;
        end else if (conversion_result_re_i) begin
            s_d.eoc = 1'b0;
        end
        s_d.ladder = s_d.mode | s_d.busy;
        if (low_power_i) begin
            s_d.st = ADCSEQ_IDLE;
            s_d.start = 1'b0;
            s_d.busy = 1'b0;
            s_d.chan = `ADCSEQ_CH_RST;
            s_d.dis = `ADCSEQ_DIS_RST;
            s_d.mode = `ADCSEQ_MODE_RST;
            s_d.tsel = `ADCSEQ_TS_RST;
            s_d.eoc = 1'b0;
            s_d.irq = 1'b0;
            s_d.result = `ADCSEQ_RESULT_RST;
            s_d.ladder = 1'b0;
            sar_if.abort = 1'b1;
            sar_if.start = 1'b0;
            sar_if.step = 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_b_i) begin
            s_q <= '0;
            s_q.st <= ADCSEQ_IDLE;
            s_q.chan <= `ADCSEQ_CH_RST;
            s_q.dis <= `ADCSEQ_DIS_RST;
            s_q.mode <= `ADCSEQ_MODE_RST;
            s_q.tsel <= `ADCSEQ_TS_RST;
            s_q.result <= `ADCSEQ_RESULT_RST;
            s_q.tconv <= `ADCSEQ_TCONV_39;
        end else begin
            s_q <= s_d;
        end
    end

    // Fixed bits read at their initial levels, so control 1 reads 8'h10 after reset
    assign converter_control_1_o = {s_q.start, 1'b0, 1'b0, s_q.dis, s_q.chan};
    assign converter_control_2_o = {2'b00, s_q.mode, 1'b1, s_q.tsel, 1'b0};
    assign converter_status_o = {2'b00, s_q.eoc, s_q.busy, 4'h0};
    assign conversion_result_o = s_q.result;
    assign conv_start_bit_o = s_q.start;
    assign conv_end_flag_o = s_q.eoc;
    assign conv_busy_flag_o = s_q.busy;
    assign conv_done_irq_o = s_q.irq;
    assign channel_select_o = s_q.chan;
    assign analog_input_disable_o = s_q.dis;
    assign ladder_connect_mode_o = s_q.mode;
    assign conv_time_sel_o = s_q.tsel;
    assign analog_reference_connect_o = s_q.ladder;
    assign sample_hold_o = s_q.busy;
    assign dac_code_o = sar_if.trial;

    // Checking helpers: length of the running conversion
    logic [`ADCSEQ_CYC_W-1:0] len_q;
    always_ff @(posedge clk_i) begin
        if (!rst_b_i || !s_q.busy) begin
            len_q <= '0;
        end else begin
            len_q <= len_q + 11'd1;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);

    start_to_busy_a: assert property (
        converter_control_1_we_i && converter_control_1_wdata_i[7] && !s_q.start
        && !s_q.busy && !low_power_i ##1 !low_power_i
        |-> conv_start_bit_o ##1 conv_busy_flag_o)
        else $error("start request did not begin a conversion");
    done_together_a: assert property (
        $rose(conv_end_flag_o) |-> conv_done_irq_o && !conv_busy_flag_o)
        else $error("end flag and done pulse not together");
    start_autoclr_a: assert property (
        conv_start_bit_o |=> !conv_start_bit_o && (conv_busy_flag_o || $past(low_power_i)))
        else $error("start bit not cleared at conversion start");
    conv_length_a: assert property (
        $fell(conv_busy_flag_o) && conv_end_flag_o |-> $past(len_q) + 11'd1 == s_q.tconv)
        else $error("conversion length differs from selected time");
    read_clears_a: assert property (
        conversion_result_re_i && !fin |=> !conv_end_flag_o)
        else $error("result read did not clear end flag");
    restart_keeps_a: assert property (
        conv_busy_flag_o && !fin && !low_power_i |=> $stable(conversion_result_o))
        else $error("result changed during a conversion");
    restart_clears_a: assert property (
        $rose(conv_busy_flag_o) |-> !conv_end_flag_o)
        else $error("end flag left set on restart");
    lp_abort_a: assert property (
        low_power_i |=> !conv_busy_flag_o && channel_select_o == 4'h0
        && analog_input_disable_o && conv_time_sel_o == 3'h0 && !ladder_connect_mode_o)
        else $error("low power entry did not reset controls");
    lp_result_a: assert property (
        low_power_i |=> conversion_result_o == 8'h00 && !conv_end_flag_o)
        else $error("result kept across low power entry");
    no_resume_a: assert property (
        $fell(low_power_i) |-> !conv_busy_flag_o ##1 !conv_busy_flag_o)
        else $error("conversion resumed after low power");
    ladder_off_a: assert property (
        low_power_i |=> !analog_reference_connect_o)
        else $error("reference still connected in low power");
    ladder_mode_a: assert property (
        !low_power_i ##1 (conv_busy_flag_o || ladder_connect_mode_o)
        |-> analog_reference_connect_o)
        else $error("ladder not connected when required");
    busy_flag_a: assert property (
        conv_busy_flag_o |-> !conv_end_flag_o && !conv_start_bit_o)
        else $error("busy overlaps end flag or start bit");
    ignore_busy_a: assert property (
        conv_busy_flag_o && converter_control_1_we_i |=> !conv_start_bit_o)
        else $error("start accepted while busy");
    steps_eight_a: assert property (
        fin |-> s_q.step == 3'd7 && len_q + 11'd1 == s_q.tconv)
        else $error("last step not at end of conversion time");

    irq_pulse_a: assert property (
        conv_done_irq_o |-> $fell(conv_busy_flag_o) ##1 !conv_done_irq_o)
        else $error("done pulse not a single cycle at conversion end");
    first_trial_a: assert property (
        $rose(conv_busy_flag_o) |-> dac_code_o == 8'h80)
        else $error("first trial is not the top bit");
    lp_trial_a: assert property (
        low_power_i |=> dac_code_o == 8'h00)
        else $error("trial code kept across low power entry");
    ladder_idle_a: assert property (
        !conv_busy_flag_o && !ladder_connect_mode_o |-> !analog_reference_connect_o)
        else $error("ladder connected outside a conversion");
    result_idle_a: assert property (
        !conv_busy_flag_o && !low_power_i |=> $stable(conversion_result_o))
        else $error("result changed while idle");
    eoc_hold_a: assert property (
        conv_end_flag_o && !conversion_result_re_i && !low_power_i && !conv_start_bit_o
        |=> conv_end_flag_o)
        else $error("end flag cleared without a read");
    chan_write_a: assert property (
        converter_control_1_we_i && !low_power_i
        |=> {4'h0, channel_select_o} == ($past(converter_control_1_wdata_i) & 8'h0f))
        else $error("channel write not taken");

    // A 1248-cycle run is too long for a delay range, so len_q marks its last cycle
    conv_done_c: cover property (conv_busy_flag_o && len_q + 11'd1 == s_q.tconv
        ##1 conv_done_irq_o);
    read_done_c: cover property (conv_end_flag_o ##1 conversion_result_re_i);
    restart_c: cover property (conv_end_flag_o && conv_start_bit_o);
    lp_abort_c: cover property (conv_busy_flag_o && low_power_i);
    poke_busy_c: cover property (conv_busy_flag_o && converter_control_1_we_i
        && converter_control_1_wdata_i[7]);
endmodule : adcseq_top

`default_nettype wire

//--- test/adcseq_testbench.sv
/*
 Self-checking bench of the converter sequencer: conversions at every time code,
 restart before read, start while busy, result read, low power abort.
 Assumes the design files under logic/ are compiled first; comp_i is fed by an
 ideal comparator model of the bench that compares a chosen input with dac_code_o.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic clk_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic we1 = 1'b0;
    logic [7:0] wdata1 = 8'h00;
    logic we2 = 1'b0;
    logic [7:0] wdata2 = 8'h00;
    logic re = 1'b0;
    logic low_power_i = 1'b0;
    logic comp_i = 1'b0;
    logic [7:0] ctrl1_o, ctrl2_o, status_o, conversion_result_o, dac_code_o;
    logic conv_start_bit_o, conv_end_flag_o, conv_busy_flag_o, conv_done_irq_o;
    logic [3:0] channel_select_o;
    logic analog_input_disable_o, ladder_connect_mode_o, ref_connect_o, sample_hold_o;
    logic [2:0] conv_time_sel_o;
    logic [7:0] vin = 8'h00;
    logic [7:0] seed = 8'h19;
    int num_errors = 0;
    int checked = 0;

    adcseq_top uut (
        .clk_i(clk_i), .rst_b_i(rst_b_i),
        .converter_control_1_we_i(we1), .converter_control_1_wdata_i(wdata1),
        .converter_control_2_we_i(we2), .converter_control_2_wdata_i(wdata2),
        .conversion_result_re_i(re), .low_power_i(low_power_i), .comp_i(comp_i),
        .converter_control_1_o(ctrl1_o), .converter_control_2_o(ctrl2_o),
        .converter_status_o(status_o), .conversion_result_o(conversion_result_o),
        .conv_start_bit_o(conv_start_bit_o), .conv_end_flag_o(conv_end_flag_o),
        .conv_busy_flag_o(conv_busy_flag_o), .conv_done_irq_o(conv_done_irq_o),
        .channel_select_o(channel_select_o), .analog_input_disable_o(analog_input_disable_o),
        .ladder_connect_mode_o(ladder_connect_mode_o), .conv_time_sel_o(conv_time_sel_o),
        .analog_reference_connect_o(ref_connect_o), .sample_hold_o(sample_hold_o),
        .dac_code_o(dac_code_o)
    );

    always #2.5 clk_i = ~clk_i;

    // Ideal comparator: input at or above the trial code reads 1
    always @(posedge clk_i) begin
        #1 comp_i <= (vin >= dac_code_o);
    end

    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr

    // Reserved codes run at the longest time
    function automatic int exp_cycles(input logic [2:0] ts);
        case (ts)
            3'h0: return 39;
            3'h2: return 78;
            3'h3: return 156;
            3'h4: return 312;
            3'h5: return 624;
            default: return 1248;
        endcase
    endfunction : exp_cycles

    task automatic print_verdict;
        $display("Comparisons %0d, mismatches %0d", checked, num_errors);
        if (num_errors == 0 && checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict

    task automatic check(input string what, input logic [10:0] seen, input logic [10:0] exp);
        checked++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %0h seen %0h", what, exp, seen);
        end
    endtask : check

    task automatic tick;
        @(posedge clk_i);
        #1;
    endtask : tick

    task automatic wr1(input logic [7:0] d);
        we1 = 1'b1;
        wdata1 = d;
        tick();
        we1 = 1'b0;
    endtask : wr1

    task automatic wr2(input logic [7:0] d);
        we2 = 1'b1;
        wdata2 = d;
        tick();
        we2 = 1'b0;
    endtask : wr2

    task automatic rd;
        re = 1'b1;
        tick();
        re = 1'b0;
        check("end flag after read", 11'(conv_end_flag_o), 11'h0);
    endtask : rd

    // One conversion; pk pokes a second start into the running conversion
    task automatic conv(input logic [2:0] ts, input logic [7:0] v, input logic m,
                        input logic pk);
        logic [7:0] old;
        int n;
        old = conversion_result_o;
        n = 0;
        vin = v;
        wr2({2'b00, m, 1'b1, ts, 1'b0});
        check("time select", 11'(conv_time_sel_o), 11'(ts));
        check("ladder mode", 11'(ladder_connect_mode_o), 11'(m));
        wr1({4'b1010, 1'b0, v[2:0]});
        check("start bit set", 11'(conv_start_bit_o), 11'h1);
        check("channel", 11'(channel_select_o), 11'(v[2:0]));
        check("input enable", 11'(analog_input_disable_o), 11'h0);
        tick();
        check("start bit cleared", 11'(conv_start_bit_o), 11'h0);
        check("busy at start", 11'(conv_busy_flag_o), 11'h1);
        check("hold at start", 11'(sample_hold_o), 11'h1);
        check("end flag at start", 11'(conv_end_flag_o), 11'h0);
        check("result kept", 11'(conversion_result_o), 11'(old));
        check("first trial", 11'(dac_code_o), 11'h80);
        // Only the deliberate poke touches the ports while converting
        while (conv_busy_flag_o === 1'b1 && n < 3000) begin
            n++;
            tick();
            we1 = (pk && n == 4);
            if (n == 3) begin
                check("ladder in conversion", 11'(ref_connect_o), 11'h1);
            end
        end
        if (n >= 3000) begin
            num_errors++;
            print_verdict();
        end
        check("busy cycles", 11'(n), 11'(exp_cycles(ts)));
        check("end flag set", 11'(conv_end_flag_o), 11'h1);
        check("done pulse", 11'(conv_done_irq_o), 11'h1);
        check("result", 11'(conversion_result_o), 11'(v));
        tick();
        check("done pulse ends", 11'(conv_done_irq_o), 11'h0);
        check("no second run", 11'(conv_busy_flag_o), 11'h0);
        check("hold released", 11'(sample_hold_o), 11'h0);
        tick();
        check("ladder when idle", 11'(ref_connect_o), 11'(m));
    endtask : conv

    initial begin
        repeat (8) tick();
        rst_b_i = 1'b1;
        check("control 1 reset", 11'(ctrl1_o), 11'h10);
        check("control 2 reset", 11'(ctrl2_o), 11'h10);
        check("status reset", 11'(status_o), 11'h00);
        check("result reset", 11'(conversion_result_o), 11'h00);
        for (int t = 0; t < 8; t++) begin
            seed = lfsr(seed);
            conv(3'(t), (t == 0) ? 8'h00 : (t == 7) ? 8'hff : seed, t[0], t == 3);
            // Skipping one read leaves the flag set for the next start to clear
            if (t != 4) begin
                rd();
            end
        end
        // Abort in mid-conversion with the ladder held on by mode
        seed = lfsr(seed);
        vin = seed;
        wr2(8'h3c);
        wr1(8'ha5);
        repeat (20) tick();
        low_power_i = 1'b1;
        tick();
        check("busy after abort", 11'(conv_busy_flag_o), 11'h0);
        check("end flag after abort", 11'(conv_end_flag_o), 11'h0);
        check("result after abort", 11'(conversion_result_o), 11'h00);
        check("control 1 after abort", 11'(ctrl1_o), 11'h10);
        check("control 2 after abort", 11'(ctrl2_o), 11'h10);
        check("reference in low power", 11'(ref_connect_o), 11'h0);
        wr1(8'ha2);
        check("write in low power", 11'(ctrl1_o), 11'h10);
        low_power_i = 1'b0;
        repeat (10) tick();
        check("no restart", 11'(conv_busy_flag_o), 11'h0);
        check("no restart start bit", 11'(conv_start_bit_o), 11'h0);
        seed = lfsr(seed);
        conv(3'h0, seed, 1'b0, 1'b0);
        print_verdict();
    end
endmodule : testbench

`default_nettype wire
